/* verilog/dpt_pkg.sv */
// dpt_pkg: constants and types shared by the memory pattern test sequencer files
// assumes: 100 MHz system clock, apb register window decoded on paddr[7:0]
package dpt_pkg;
    localparam int ADDR_W = 14;
    localparam int CNT_W = 15;
    localparam int SCAN_W = 5;
    localparam int RES_W = 1 + ADDR_W + CNT_W;
    localparam int RES_DEPTH = 18;
    localparam int BYTE_BITS = 8;
    localparam logic [ADDR_W-1:0] PRI_LAST = 14'h3fff;
    localparam logic [ADDR_W-1:0] SEC_LAST = 14'h0fff;
    localparam logic [SCAN_W-1:0] SCAN_ZERO = 5'h01;
    localparam logic [SCAN_W-1:0] SCAN_ONE = 5'h02;
    localparam logic [SCAN_W-1:0] SCAN_PAT_FIRST = 5'h03;
    localparam logic [SCAN_W-1:0] SCAN_PAT_LAST = 5'h12;
    localparam logic [7:0] PAT_FIRST_BYTE = 8'hf1;
    // register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_REPEAT = 8'h08;
    localparam logic [7:0] OFF_TOTAL = 8'h0c;
    localparam logic [7:0] OFF_PASS = 8'h10;
    localparam logic [7:0] OFF_FAIL = 8'h14;
    localparam logic [7:0] OFF_RES_IDX = 8'h18;
    localparam logic [7:0] OFF_RES_DATA = 8'h1c;
    // field positions
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_LONG_BIT = 1;
    localparam int CTRL_FAM_BIT = 2;
    // reset values
    localparam logic CTRL_LONG_RST = 1'b1;
    localparam logic CTRL_FAM_RST = 1'b0;
    localparam logic [7:0] REPEAT_RST = 8'h01;
    // long-test duration targets and derived per-access pacing
    localparam longint CLK_HZ = 100_000_000;
    localparam longint LONG_PRI_S = 28;
    localparam longint LONG_SEC_S = 10;
    localparam longint PRI_ACCESSES = 2 * RES_DEPTH * (longint'(PRI_LAST) + 1);
    localparam longint SEC_ACCESSES = 2 * RES_DEPTH * (longint'(SEC_LAST) + 1);
    localparam int PACE_PRI_CYC = int'(LONG_PRI_S * CLK_HZ / PRI_ACCESSES);
    localparam int PACE_SEC_CYC = int'(LONG_SEC_S * CLK_HZ / SEC_ACCESSES);

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_WAIT = 3'b001,
        ST_ACC = 3'b011,
        ST_SCAN = 3'b010,
        ST_RUN = 3'b110
    } dpt_state_type;

    typedef enum logic [1:0] {
        MENU_MAIN = 2'b00,
        MENU_STATS = 2'b01,
        MENU_REPEAT = 2'b11
    } dpt_menu_type;
endpackage : dpt_pkg

/* verilog/dpt_res_if.sv */
// dpt_res_if: per-scan result store port between sequencer and result memory
// assumes: both ends on sys_clk
`timescale 1ns/1ns
interface dpt_res_if;
    import dpt_pkg::*;
    logic wr_en;
    logic [SCAN_W-1:0] wr_idx;
    logic [RES_W-1:0] wr_data;
    logic [SCAN_W-1:0] rd_idx;
    logic [RES_W-1:0] rd_data;
    modport seq (output wr_en, output wr_idx, output wr_data, output rd_idx, input rd_data);
    modport mem (input wr_en, input wr_idx, input wr_data, input rd_idx, output rd_data);
endinterface : dpt_res_if

/* verilog/dpt_result_mem.sv */
// dpt_result_mem: one word per scan (first bad address, seen flag, bad-bit count)
// assumes: read index held steady; read data appears one clock later
`timescale 1ns/1ns
module dpt_result_mem #(
    parameter int DEPTH = dpt_pkg::RES_DEPTH
) (
    input wire logic sys_clk,
    input wire logic rst,
    dpt_res_if.mem res
);
    import dpt_pkg::*;

    logic [RES_W-1:0] mem_array [DEPTH];

    always_ff @(posedge sys_clk) begin
        if (res.wr_en && int'(res.wr_idx) < DEPTH) begin
            mem_array[res.wr_idx] <= res.wr_data;
        end
    end

    // out-of-range indices read as zero instead of undefined storage
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            res.rd_data <= '0;
        end else if (int'(res.rd_idx) < DEPTH) begin
            res.rd_data <= mem_array[res.rd_idx];
        end else begin
            res.rd_data <= '0;
        end
    end
endmodule : dpt_result_mem

/* verilog/dpt_sequencer.sv */
// dpt_sequencer: memory pattern test sequencer with keypad menu and apb registers
// assumes: keys are one-cycle pulses; memory port answers each held mem_req with one mem_ack pulse
// Functional notes
// - scan one writes zero everywhere, then reads back comparing to zero.
// - scan two writes one everywhere, then reads back comparing to one.
// - long option set runs long test; clear runs scans one and two only.
// - long test adds pattern scans three through eighteen.
// - pattern scans group eight consecutive bits into one pattern byte.
// - two counters make patterns; first decrements, second increments each step.
// - byte high nibble from decrementing counter, low nibble from incrementing counter.
// - counters start at zero, step before each byte; scan three begins 0xF1.
// - each later pattern scan starts one counter step further on.
// - long/short option only for primary family; secondary always runs long.
// - long test lasts about 28 s primary, about 10 s secondary.
// - indicator orange while running, then green on pass or red on fail.
// - per scan keep first bad address and bad-bit count, readable afterwards.
// - keep counts of tests run, passed and failed.
// - repeat menu: left adds 10, right adds 1, enter sets 1, up/down leave.
// - one start runs the test repeat-count times without further starts.
// - stats and repeat menus only with failure flag clear; left/right clears it.
// - each family has its own statistics and repeat count.
// - failure flag stays set across later scans of the same test.
// - memory stays powered through all repetitions of a run.
//
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ns
module dpt_sequencer #(
    parameter int unsigned PACE_PRI = dpt_pkg::PACE_PRI_CYC,
    parameter int unsigned PACE_SEC = dpt_pkg::PACE_SEC_CYC,
    parameter int REP_W = 8,
    parameter int STAT_W = 16
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic key_left,
    input wire logic key_right,
    input wire logic key_up,
    input wire logic key_down,
    input wire logic key_enter,
    output logic mem_req,
    output logic mem_we,
    output logic [dpt_pkg::ADDR_W-1:0] mem_addr,
    output logic mem_wdata,
    output logic mem_power,
    input wire logic mem_ack,
    input wire logic mem_rdata,
    output logic led_orange,
    output logic led_green,
    output logic led_red,
    output logic [1:0] menu_sel
);
    import dpt_pkg::*;

    if (PACE_PRI < 1 || PACE_SEC < 1 || REP_W < 4 || REP_W > 31 || STAT_W < 1 || STAT_W > 32) begin : g_chk
        $error("dpt_sequencer: unsupported parameter value");
    end

    dpt_state_type st_reg;
    dpt_menu_type menu_reg;
    logic pass_rd_reg, step_due_reg, run_fam_reg, run_long_reg, run_err_reg, fail_flag_reg, done_reg;
    logic fam_reg, long_reg, first_seen_reg;
    logic [SCAN_W-1:0] scan_reg, res_idx_reg;
    logic [ADDR_W-1:0] first_addr_reg;
    logic [CNT_W-1:0] bad_cnt_reg;
    logic [31:0] pace_reg;
    logic [7:0] c_dec_reg, c_inc_reg, off;
    logic [REP_W-1:0] runs_left_reg;
    logic [REP_W-1:0] repeat_reg [2];
    logic [STAT_W-1:0] stat_tot_reg [2];
    logic [STAT_W-1:0] stat_pass_reg [2];
    logic [STAT_W-1:0] stat_fail_reg [2];
    logic [7:0] pat_byte;
    logic exp_bit, idle, apb_wr, apb_start, start_req, more_runs, scan_start, cmp_bad, at_main;
    logic [ADDR_W-1:0] last_addr;
    logic [SCAN_W-1:0] last_scan, next_scan;
    logic [31:0] pace_val, rd_val;
    logic rd_ok;

    dpt_res_if res_bus ();

    dpt_result_mem #(.DEPTH(RES_DEPTH)) u_res (
        .sys_clk(sys_clk),
        .rst(rst),
        .res(res_bus.mem)
    );

    assign idle = (st_reg == ST_IDLE);
    assign at_main = idle && (menu_reg == MENU_MAIN);
    assign apb_wr = psel && penable && pwrite && pready;
    assign apb_start = apb_wr && (paddr == OFF_CTRL) && pwdata[CTRL_START_BIT];
    assign start_req = idle && ((key_enter && menu_reg == MENU_MAIN) || apb_start);
    assign more_runs = (st_reg == ST_RUN) && (runs_left_reg > 1);
    assign last_addr = run_fam_reg ? SEC_LAST : PRI_LAST;
    assign last_scan = run_long_reg ? SCAN_PAT_LAST : SCAN_ONE;
    assign next_scan = (st_reg == ST_SCAN) ? scan_reg + 1'b1 : SCAN_ZERO;
    assign scan_start = start_req || more_runs || (st_reg == ST_SCAN && scan_reg != last_scan);
    assign off = 8'(next_scan - SCAN_PAT_FIRST);
    assign pace_val = run_fam_reg ? PACE_SEC : PACE_PRI;
    assign pat_byte = {c_dec_reg[3:0], c_inc_reg[3:0]};
    // bit k of a pattern byte goes to the k-th location of its group of eight
    assign exp_bit = (scan_reg == SCAN_ZERO) ? 1'b0 : (scan_reg == SCAN_ONE) ? 1'b1 : pat_byte[mem_addr[2:0]];
    assign cmp_bad = (st_reg == ST_ACC) && mem_ack && pass_rd_reg && (mem_rdata != mem_wdata);

    assign res_bus.wr_en = (st_reg == ST_SCAN);
    assign res_bus.wr_idx = scan_reg - 1'b1;
    assign res_bus.wr_data = {first_seen_reg, first_addr_reg, bad_cnt_reg};
    assign res_bus.rd_idx = res_idx_reg;

    // scan sequencer: pace, request, wait for answer, step address
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_reg <= ST_IDLE;
            scan_reg <= SCAN_ZERO;
            pass_rd_reg <= 1'b0;
            mem_addr <= '0;
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            mem_wdata <= 1'b0;
            pace_reg <= '0;
            c_dec_reg <= '0;
            c_inc_reg <= '0;
            step_due_reg <= 1'b0;
            runs_left_reg <= '0;
            run_fam_reg <= 1'b0;
            run_long_reg <= 1'b0;
        end else begin
            if (scan_start) begin
                st_reg <= ST_WAIT;
                scan_reg <= next_scan;
                pass_rd_reg <= 1'b0;
                mem_addr <= '0;
                pace_reg <= pace_val;
                c_dec_reg <= 8'(8'h00 - off);
                c_inc_reg <= off;
                step_due_reg <= 1'b1;
            end
            if (start_req) begin
                run_fam_reg <= fam_reg;
                run_long_reg <= long_reg || fam_reg;
                runs_left_reg <= (repeat_reg[fam_reg] == '0) ? REP_W'(1) : repeat_reg[fam_reg];
                pace_reg <= fam_reg ? PACE_SEC : PACE_PRI;
            end
            case (st_reg)
                ST_WAIT: begin
                    if (pace_reg != 0) begin
                        pace_reg <= pace_reg - 1;
                    end
                    if (step_due_reg) begin
                        c_dec_reg <= c_dec_reg - 8'h01;
                        c_inc_reg <= c_inc_reg + 8'h01;
                        step_due_reg <= 1'b0;
                    end else if (pace_reg <= 1) begin
                        st_reg <= ST_ACC;
                        mem_req <= 1'b1;
                        mem_we <= !pass_rd_reg;
                        mem_wdata <= exp_bit;
                    end
                end
                ST_ACC: begin
                    if (mem_ack) begin
                        mem_req <= 1'b0;
                        pace_reg <= pace_val;
                        if (mem_addr != last_addr) begin
                            st_reg <= ST_WAIT;
                            mem_addr <= mem_addr + 1'b1;
                            step_due_reg <= (mem_addr[2:0] == 3'h7);
                        end else if (!pass_rd_reg) begin
                            // read pass regenerates the same sequence from the scan's start
                            st_reg <= ST_WAIT;
                            pass_rd_reg <= 1'b1;
                            mem_addr <= '0;
                            c_dec_reg <= 8'(8'h00 - 8'(scan_reg - SCAN_PAT_FIRST));
                            c_inc_reg <= 8'(scan_reg - SCAN_PAT_FIRST);
                            step_due_reg <= 1'b1;
                        end else begin
                            st_reg <= ST_SCAN;
                        end
                    end
                end
                ST_SCAN: begin
                    if (scan_reg == last_scan) begin
                        st_reg <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (more_runs) begin
                        runs_left_reg <= runs_left_reg - 1'b1;
                    end else begin
                        st_reg <= ST_IDLE;
                    end
                end
                default: begin
                    if (!scan_start) begin
                        st_reg <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // supply stays on from the start command until the last repetition ends
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            mem_power <= 1'b0;
        end else if (start_req) begin
            mem_power <= 1'b1;
        end else if (st_reg == ST_RUN && !more_runs) begin
            mem_power <= 1'b0;
        end
    end

    // per-scan mismatch record
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            first_seen_reg <= 1'b0;
            first_addr_reg <= '0;
            bad_cnt_reg <= '0;
        end else if (scan_start) begin
            first_seen_reg <= 1'b0;
            bad_cnt_reg <= '0;
        end else if (cmp_bad) begin
            if (bad_cnt_reg != '1) begin
                bad_cnt_reg <= bad_cnt_reg + 1'b1;
            end
            if (!first_seen_reg) begin
                first_seen_reg <= 1'b1;
                first_addr_reg <= mem_addr;
            end
        end
    end

    // run error clears per repetition; failure flag only by start or left/right
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            run_err_reg <= 1'b0;
            fail_flag_reg <= 1'b0;
        end else begin
            if (cmp_bad) begin
                run_err_reg <= 1'b1;
                fail_flag_reg <= 1'b1;
            end else begin
                if (start_req || more_runs) begin
                    run_err_reg <= 1'b0;
                end
                if (start_req || (at_main && (key_left || key_right))) begin
                    fail_flag_reg <= 1'b0;
                end
            end
        end
    end

    // statistics, one set per family
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            stat_tot_reg <= '{default: '0};
            stat_pass_reg <= '{default: '0};
            stat_fail_reg <= '{default: '0};
        end else if (st_reg == ST_RUN) begin
            stat_tot_reg[run_fam_reg] <= stat_tot_reg[run_fam_reg] + 1'b1;
            if (run_err_reg) begin
                stat_fail_reg[run_fam_reg] <= stat_fail_reg[run_fam_reg] + 1'b1;
            end else begin
                stat_pass_reg[run_fam_reg] <= stat_pass_reg[run_fam_reg] + 1'b1;
            end
        end
    end

    // keypad menu, family and option selection, repeat counts; keys ignored while busy
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            menu_reg <= MENU_MAIN;
            fam_reg <= CTRL_FAM_RST;
            long_reg <= CTRL_LONG_RST;
            repeat_reg <= '{default: REP_W'(REPEAT_RST)};
        end else if (idle) begin
            if (apb_wr && paddr == OFF_CTRL) begin
                fam_reg <= pwdata[CTRL_FAM_BIT];
                long_reg <= pwdata[CTRL_LONG_BIT];
            end
            if (apb_wr && paddr == OFF_REPEAT) begin
                repeat_reg[fam_reg] <= pwdata[REP_W-1:0];
            end
            case (menu_reg)
                MENU_MAIN: begin
                    if (key_left || key_right) begin
                        fam_reg <= !fam_reg;
                    end else if (key_down && !fail_flag_reg) begin
                        menu_reg <= MENU_STATS;
                    end else if (key_up && !fail_flag_reg) begin
                        menu_reg <= MENU_REPEAT;
                    end
                end
                MENU_STATS: begin
                    if (key_down) begin
                        menu_reg <= MENU_REPEAT;
                    end else if (key_up) begin
                        menu_reg <= MENU_MAIN;
                    end
                end
                MENU_REPEAT: begin
                    if (key_up || key_down) begin
                        menu_reg <= MENU_MAIN;
                    end else if (key_left) begin
                        repeat_reg[fam_reg] <= ({1'b0, repeat_reg[fam_reg]} + 10 > {1'b0, {REP_W{1'b1}}}) ?
                            {REP_W{1'b1}} : REP_W'(repeat_reg[fam_reg] + 10);
                    end else if (key_right) begin
                        if (repeat_reg[fam_reg] != {REP_W{1'b1}}) begin
                            repeat_reg[fam_reg] <= repeat_reg[fam_reg] + 1'b1;
                        end
                    end else if (key_enter) begin
                        repeat_reg[fam_reg] <= REP_W'(1);
                    end
                end
                default: begin
                    menu_reg <= MENU_MAIN;
                end
            endcase
        end
    end

    // result indicator
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            done_reg <= 1'b0;
            led_orange <= 1'b0;
            led_green <= 1'b0;
            led_red <= 1'b0;
        end else begin
            if (st_reg == ST_RUN && !more_runs) begin
                done_reg <= 1'b1;
            end
            led_orange <= !idle;
            led_green <= idle && done_reg && !fail_flag_reg;
            led_red <= idle && done_reg && fail_flag_reg;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            menu_sel <= MENU_MAIN;
        end else begin
            menu_sel <= menu_reg;
        end
    end

    always_comb begin
        rd_ok = 1'b1;
        rd_val = '0;
        case (paddr)
            OFF_CTRL: rd_val = 32'({fam_reg, long_reg, 1'b0});
            OFF_STATUS: rd_val = 32'({menu_reg, runs_left_reg, scan_reg, run_err_reg, fail_flag_reg, !idle});
            OFF_REPEAT: rd_val = 32'(repeat_reg[fam_reg]);
            OFF_TOTAL: rd_val = 32'(stat_tot_reg[fam_reg]);
            OFF_PASS: rd_val = 32'(stat_pass_reg[fam_reg]);
            OFF_FAIL: rd_val = 32'(stat_fail_reg[fam_reg]);
            OFF_RES_IDX: rd_val = 32'(res_idx_reg);
            OFF_RES_DATA: rd_val = 32'(res_bus.rd_data);
            default: rd_ok = 1'b0;
        endcase
    end

    // one wait state keeps prdata, pready and pslverr straight from flip-flops
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
            res_idx_reg <= '0;
        end else begin
            pready <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !rd_ok;
            prdata <= (psel && penable && !pready && !pwrite && rd_ok) ? rd_val : '0;
            if (apb_wr && paddr == OFF_RES_IDX) begin
                res_idx_reg <= pwdata[SCAN_W-1:0];
            end
        end
    end

    sequence s_issue_write;
        $rose(mem_req) && mem_we;
    endsequence

    sequence s_last_scan_done;
        st_reg == ST_SCAN && scan_reg == last_scan;
    endsequence

    a_zero_scan_data: assert property (@(posedge sys_clk) disable iff (rst)
        s_issue_write and (scan_reg == SCAN_ZERO) |-> !mem_wdata) else $error("scan one wrote a one");
    a_one_scan_data: assert property (@(posedge sys_clk) disable iff (rst)
        s_issue_write and (scan_reg == SCAN_ONE) |-> mem_wdata) else $error("scan two wrote a zero");
    a_short_test_end: assert property (@(posedge sys_clk) disable iff (rst)
        st_reg == ST_SCAN && scan_reg == SCAN_ONE && !run_long_reg |=> st_reg == ST_RUN)
        else $error("short test went past scan two");
    a_secondary_long: assert property (@(posedge sys_clk) disable iff (rst)
        st_reg == ST_SCAN && scan_reg == SCAN_ONE && run_fam_reg |=> st_reg == ST_WAIT && scan_reg == SCAN_PAT_FIRST)
        else $error("secondary family skipped pattern scans");
    a_pattern_first: assert property (@(posedge sys_clk) disable iff (rst)
        s_issue_write and (scan_reg == SCAN_PAT_FIRST && mem_addr < BYTE_BITS) |->
        mem_wdata == PAT_FIRST_BYTE[mem_addr[2:0]]) else $error("first pattern byte wrong");
    a_counter_step: assert property (@(posedge sys_clk) disable iff (rst)
        st_reg == ST_WAIT && step_due_reg |=> c_dec_reg == $past(c_dec_reg) - 8'h01 &&
        c_inc_reg == $past(c_inc_reg) + 8'h01) else $error("pattern counters did not step");
    a_flag_sticky: assert property (@(posedge sys_clk) disable iff (rst)
        fail_flag_reg && !idle |=> fail_flag_reg) else $error("failure flag dropped mid test");
    a_led_running: assert property (@(posedge sys_clk) disable iff (rst)
        !idle ##1 !idle |-> led_orange && !led_green && !led_red) else $error("indicator not orange");
    a_power_held: assert property (@(posedge sys_clk) disable iff (rst)
        s_last_scan_done ##1 more_runs |=> mem_power ##1 mem_power) else $error("power dropped between runs");
    a_first_capture: assert property (@(posedge sys_clk) disable iff (rst)
        cmp_bad && !first_seen_reg |=> first_seen_reg && first_addr_reg == $past(mem_addr))
        else $error("first bad address not captured");
endmodule : dpt_sequencer

/* sim/dpt_mem_model.sv */
// dpt_mem_model: single-bit memory under test with one faulty cell
// assumes: sequencer holds mem_req until it sees one mem_ack pulse
`timescale 1ns/1ns
module dpt_mem_model #(
    parameter int BAD_ADDR = 5
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [dpt_pkg::ADDR_W-1:0] mem_addr,
    input wire logic mem_wdata,
    output logic mem_ack,
    output logic mem_rdata
);
    logic cells [0:(1<<dpt_pkg::ADDR_W)-1];
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            mem_ack <= 1'b0;
            mem_rdata <= 1'b0;
        end else if (mem_ack || !mem_req) begin
            // read bit not valid outside the ack cycle: keep it moving
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
        end else begin
            mem_ack <= 1'b1;
            if (mem_we) cells[mem_addr] <= mem_wdata;
            mem_rdata <= cells[mem_addr] ^ (mem_addr == BAD_ADDR);
        end
    end
endmodule : dpt_mem_model

/* sim/dram_pattern_test_sequencer_bench.sv */
// bench: apb register checks, keypad menus and a faulty secondary-family test
// assumes: pacing parameters shortened to 2 cycles
`timescale 1ns/1ns
module dram_pattern_test_sequencer_bench;
    import dpt_pkg::*;
    logic sys_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, q;
    logic [4:0] keys = '0;
    logic mem_req, mem_we, mem_wdata, mem_power, mem_ack, mem_rdata, led_orange, led_green, led_red;
    logic [ADDR_W-1:0] mem_addr;
    logic [1:0] menu_sel;
    int miscompares = 0, cmp_count = 0, n;
    always #5 sys_clk = ~sys_clk;
    dpt_sequencer #(.PACE_PRI(2), .PACE_SEC(2)) u_dpt_sequencer (.sys_clk(sys_clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .key_left(keys[0]), .key_right(keys[1]), .key_up(keys[2]), .key_down(keys[3]),
        .key_enter(keys[4]), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_power(mem_power), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .led_orange(led_orange),
        .led_green(led_green), .led_red(led_red), .menu_sel(menu_sel));
    dpt_mem_model u_dpt_mem_model (.sys_clk(sys_clk), .rst(rst), .mem_req(mem_req), .mem_we(mem_we),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
    task report_and_stop;
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : report_and_stop
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task give_up;
        miscompares++;
        $display("[ERR] %0t wait timed out", $time);
        report_and_stop();
    endtask : give_up
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge sys_clk) penable <= 1'b1;
        @(posedge sys_clk);
        // pready read right after the edge is the value the edge sampled
        for (n = 0; n < 20 && pready !== 1'b1; n++) @(posedge sys_clk);
        if (pready !== 1'b1) give_up();
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // one idle edge so a following call never re-drives psel in this time step
        @(posedge sys_clk);
    endtask : apb
    task key(input int i);
        keys[i] <= 1'b1;
        @(posedge sys_clk) keys <= '0;
        repeat (2) @(posedge sys_clk);
    endtask : key
    task regs_after_reset;
        apb(0, OFF_CTRL, 0); chk(q, 32'h0000_0002);
        apb(0, OFF_REPEAT, 0); chk(q, 32'h0000_0001);
        apb(0, OFF_TOTAL, 0); chk(q, 32'h0000_0000);
        apb(0, 8'h40, 0); chk(err, 1);
    endtask : regs_after_reset
    task menus_and_repeat;
        key(3); chk(menu_sel, 2'b01);
        key(2); key(2); chk(menu_sel, 2'b11);
        key(1); key(0); apb(0, OFF_REPEAT, 0); chk(q, 32'h0000_000c);
        key(4); key(1); apb(0, OFF_REPEAT, 0); chk(q, 32'h0000_0002);
        key(3); chk(menu_sel, 2'b00);
        key(0); apb(0, OFF_REPEAT, 0); chk(q, 32'h0000_0001);
        key(1); apb(0, OFF_REPEAT, 0); chk(q, 32'h0000_0002);
    endtask : menus_and_repeat
    task fault_scan_secondary;
        // small secondary array keeps scan one's result within the cycle budget
        apb(1, OFF_CTRL, 32'h0000_0004); apb(0, OFF_CTRL, 0); chk(q, 32'h0000_0004);
        apb(1, OFF_CTRL, 32'h0000_0005);
        for (n = 0; n < 20000 && !(mem_req === 1'b1 && mem_we === 1'b0); n++) @(negedge sys_clk);
        if (n == 20000) give_up();
        chk({mem_addr, mem_wdata}, 0);
        for (n = 0; n < 500 && !(mem_req === 1'b1 && mem_addr === 8); n++) @(negedge sys_clk);
        if (n == 500) give_up();
        @(posedge sys_clk);
        chk({led_orange, led_green, led_red, mem_power}, 4'b1001);
        apb(0, OFF_STATUS, 0); chk(q[1:0], 2'b11);
        apb(1, OFF_RES_IDX, 0);
        // scan two writes ones only after scan one's result word is stored
        for (n = 0; n < 20000 && {mem_req, mem_we, mem_wdata} !== 3'b111; n++) @(negedge sys_clk);
        if (n == 20000) give_up();
        chk(mem_addr, 0);
        apb(0, OFF_STATUS, 0); chk(q[7:0], 8'h17);
        apb(0, OFF_RES_DATA, 0); chk(q[29:0], (1 << 29) | (5 << 15) | 1);
    endtask : fault_scan_secondary
    initial begin
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        regs_after_reset();
        menus_and_repeat();
        fault_scan_secondary();
        report_and_stop();
    end
endmodule : dram_pattern_test_sequencer_bench
